// File: epa_dev_model.sv
// epa_dev_model: behavioural model of the on-chip eprom seen through its programming pins
`timescale 1ns/1ps
module epa_dev_model
   import epa_pkg::*;
(
   // pins from the programmer
   input epa_pkg::epa_pins_t pins_i,
   input wire logic [7:0] bus_i,
   // byte lines driven back
   output logic [7:0] drv_o,
   output logic [7:0] drv_oe_n_o
);
   // ******************************************************************
   // storage
   // ******************************************************************
   logic [7:0] mem_q [0:8191];  // 8k byte cells
   logic prot_q;                // protect cell, erased high
   wire logic strobe_n = pins_i.write_strobe_n;
   wire logic top_line = bus_i[7];
   wire logic [12:0] addr = pins_i.byte_address_lines;
   // all cells start erased, so every bit reads as one
   initial begin
      for (int i = 0; i < 8192; i++) begin
         mem_q[i] = EPA_ERASED;
      end
      prot_q = 1'b1;
   end
   // a cell is written at the end of the strobe pulse; and-ing can only clear bits
   always @(posedge strobe_n) begin
      if (!pins_i.chip_en_n && pins_i.out_en_n && !pins_i.test_mode_select) begin
         mem_q[addr] = mem_q[addr] & bus_i;
      end
   end
   // protect cell is cleared by a low pulse on the top line, only with the mode pins set
   wire logic prot_mode = pins_i.chip_en_n && pins_i.out_en_n && strobe_n &&
                          pins_i.test_mode_select && addr[4] && !pins_i.byte_lines_oe_n[7];
   logic armed = 1'b0;          // a low pulse began in protect mode
   // a floating line that starts being driven high is no pulse, so arm on the fall
   always @(negedge top_line) begin
      armed = prot_mode;
   end
   always @(posedge top_line) begin
      if (armed && prot_mode) begin
         prot_q = 1'b0;
      end
      armed = 1'b0;
   end
   // drive back only while selected; a protected part hides its contents
   always @* begin
      drv_o = 8'h00;
      drv_oe_n_o = 8'hff;
      if (!pins_i.chip_en_n && !pins_i.out_en_n && strobe_n && !pins_i.test_mode_select) begin
         drv_oe_n_o = 8'h00;
         drv_o = prot_q ? mem_q[addr] : 8'h00;
      end else if (!pins_i.chip_en_n && !pins_i.out_en_n && pins_i.test_mode_select && !addr[6]) begin
         drv_oe_n_o = 8'h7f;
         drv_o = {prot_q, 7'h00};
      end
   end
endmodule

// File: epa_host.sv
// epa_host: programmer-side controller that drives the eprom programming-mode pins
`timescale 1ns/1ps
module epa_host
   import epa_pkg::*;
#(
   parameter int FAST_CYC = EPA_FAST_CYC,     // fast initial pulse, cycles
   parameter int SHORT_CYC = EPA_SHORT_CYC,   // short initial pulse, cycles
   parameter int FINAL_CYC = EPA_FINAL_CYC,   // final pulse, cycles
   parameter int SETUP_CYC = EPA_SETUP_CYC    // setup and hold, cycles
) (
   // clock, reset, enable
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   // user request
   input wire logic req_valid_i,
   input epa_pkg::epa_req_t req_i,
   output logic req_ready_o,
   // user answer
   output logic done_o,
   output logic [7:0] rdata_o,
   output logic blank_o,
   // device pins
   output epa_pkg::epa_pins_t pins_o,
   input wire logic [7:0] byte_lines_i
);
   import epa_pkg::*;

   // ********************************************************************
   // state
   // ********************************************************************
   typedef enum logic [2:0] {
      EPA_IDLE   = 3'b000,  // pins parked
      EPA_SETUP  = 3'b001,  // address and levels settle
      EPA_PULSE  = 3'b011,  // strobe, output enable or top line low
      EPA_HOLD   = 3'b010,  // data hold after pulse
      EPA_FINAL  = 3'b110,  // final strobe pulse
      EPA_FHOLD  = 3'b111   // hold after final pulse
   } epa_state_t;

   epa_state_t state_q, state_d;        // sequencer state
   epa_req_t cur_q, cur_d;              // latched request
   logic [EPA_CNT_W-1:0] cnt_q, cnt_d;  // phase timer
   logic [7:0] rdata_q, rdata_d;        // captured byte
   logic done_q, done_d;                // answer pulse
   epa_pins_t pins_q, pins_d;           // registered pins
   logic [7:0] rd_sync;                 // synchronised byte lines
   logic rd_stable;                     // synchroniser settled

   // ********************************************************************
   // byte line read-back
   // ********************************************************************
   epa_sync #(.W(EPA_DATA_W)) u_sync (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .clk_en_i(clk_en_i),
      .async_i(byte_lines_i),
      .sync_o(rd_sync),
      .stable_o(rd_stable)
   );

   // cycle count for a timing figure as a counter value
   function automatic logic [EPA_CNT_W-1:0] cyc(input int n);
      cyc = EPA_CNT_W'(n - 1);
   endfunction

   // parked pins: strobe, enables high, byte lines released
   function automatic epa_pins_t park(input logic [12:0] a);
      park.chip_en_n = 1'b1;
      park.out_en_n = 1'b1;
      park.write_strobe_n = 1'b1;
      park.test_mode_select = 1'b0;
      park.byte_address_lines = a;         // never high voltage here
      park.byte_lines_o = EPA_ERASED;
      park.byte_lines_oe_n = 8'hff;
   endfunction

   // pin levels for one operation, strobe and output enable still high
   function automatic epa_pins_t levels(input epa_req_t r);
      levels = park(r.addr);         // address as given; word halves even/odd
      case (r.op)
         EPA_OP_PROGRAM: begin
            levels.chip_en_n = 1'b0;
            levels.byte_lines_o = r.data;
            levels.byte_lines_oe_n = 8'h00;
         end
         EPA_OP_READ: begin
            levels.chip_en_n = 1'b0;
         end
         EPA_OP_PROTECT: begin
            levels.test_mode_select = 1'b1;
            levels.byte_address_lines[EPA_PROT_SET_BIT] = 1'b1;
            levels.byte_lines_o = EPA_ERASED;
            levels.byte_lines_oe_n = 8'h7f;               // only top line driven
         end
         EPA_OP_PROT_VF: begin
            levels.chip_en_n = 1'b0;
            levels.test_mode_select = 1'b1;
            levels.byte_address_lines[EPA_PROT_VFY_BIT] = 1'b0;
         end
         default: begin
            levels = park(r.addr);
         end
      endcase
   endfunction

   // ********************************************************************
   // sequencer
   // ********************************************************************
   // next-state: one request walks setup, pulse, hold, optional final
   always_comb begin
      state_d = state_q;
      cur_d = cur_q;
      cnt_d = cnt_q;
      rdata_d = rdata_q;
      done_d = 1'b0;
      pins_d = pins_q;
      case (state_q)
         EPA_IDLE: begin
            pins_d = park(pins_q.byte_address_lines);
            if (req_valid_i) begin   // one at a time, in caller order
               cur_d = req_i;
               pins_d = levels(req_i);
               cnt_d = cyc(SETUP_CYC);
               state_d = EPA_SETUP;
            end
         end
         EPA_SETUP: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               // reads pulse output enable; protect pulses the top line; program pulses the strobe
               if (cur_q.op == EPA_OP_READ || cur_q.op == EPA_OP_PROT_VF) begin
                  pins_d.out_en_n = 1'b0;
                  cnt_d = cyc(SETUP_CYC);
               end else if (cur_q.op == EPA_OP_PROTECT) begin
                  pins_d.byte_lines_o[EPA_TOP_LINE] = 1'b0; // top line pulse
                  cnt_d = cur_q.fast_alg ? cyc(FAST_CYC) : cyc(SHORT_CYC);
               end else begin
                  pins_d.write_strobe_n = 1'b0;
                  // initial pulse width by algorithm
                  cnt_d = cur_q.fast_alg ? cyc(FAST_CYC) : cyc(SHORT_CYC);
               end
               state_d = EPA_PULSE;
            end
         end
         EPA_PULSE: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               // with output enable low, sample only when the synchroniser has settled
               if (!pins_q.out_en_n && !rd_stable) begin
                  cnt_d = '0;
               end else begin
                  rdata_d = rd_sync;
                  pins_d.out_en_n = 1'b1;
                  pins_d.write_strobe_n = 1'b1;
                  pins_d.byte_lines_o[EPA_TOP_LINE] = cur_q.data[EPA_TOP_LINE] |
                     (cur_q.op == EPA_OP_PROTECT);
                  cnt_d = cyc(SETUP_CYC);
                  state_d = EPA_HOLD;
               end
            end
         end
         EPA_HOLD: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else if (cur_q.op == EPA_OP_PROGRAM && cur_q.fast_alg &&
                         cur_q.final_pulse) begin
               // longer final pulse, fast algorithm only
               pins_d.write_strobe_n = 1'b0;
               cnt_d = cyc(FINAL_CYC);
               state_d = EPA_FINAL;
            end else begin
               pins_d = park(cur_q.addr);
               done_d = 1'b1;
               state_d = EPA_IDLE;
            end
         end
         EPA_FINAL: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               pins_d.write_strobe_n = 1'b1;
               cnt_d = cyc(SETUP_CYC);
               state_d = EPA_FHOLD;
            end
         end
         EPA_FHOLD: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               pins_d = park(cur_q.addr);
               done_d = 1'b1;
               state_d = EPA_IDLE;
            end
         end
         default: begin
            state_d = EPA_IDLE;
            pins_d = park(13'h0000);
         end
      endcase
   end

   // register the sequencer; enable low freezes everything
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_q <= EPA_IDLE;
         cur_q <= '0;
         cnt_q <= '0;
         rdata_q <= EPA_ERASED;
         done_q <= 1'b0;
         pins_q <= {1'b1, 1'b1, 1'b1, 1'b0, 13'h0000, 8'hff, 8'hff};
      end else if (clk_en_i) begin
         state_q <= state_d;
         cur_q <= cur_d;
         cnt_q <= cnt_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
         pins_q <= pins_d;
      end
   end

   // ********************************************************************
   // outputs
   // ********************************************************************
   assign req_ready_o = (state_q == EPA_IDLE);
   assign done_o = done_q;
   assign rdata_o = rdata_q;
   // blank means erased byte; ones can only become zeros
   assign blank_o = (rdata_q == EPA_ERASED);
   assign pins_o = pins_q;

   // ********************************************************************
   // checks
   // ********************************************************************
   a_no_drive_fight: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !pins_o.out_en_n |-> (pins_o.byte_lines_oe_n == 8'hff))
      else $error("byte lines driven while output enable low");
   a_strobe_needs_ce: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !pins_o.write_strobe_n |-> !pins_o.chip_en_n && pins_o.out_en_n)
      else $error("strobe low without chip enable or with output enable");
   a_strobe_idle_high: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (state_q == EPA_IDLE) |-> pins_o.write_strobe_n)
      else $error("strobe low while idle");
   a_protect_levels: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (state_q == EPA_PULSE && cur_q.op == EPA_OP_PROTECT) |->
      pins_o.chip_en_n && pins_o.test_mode_select &&
      pins_o.byte_address_lines[EPA_PROT_SET_BIT] && !pins_o.byte_lines_o[EPA_TOP_LINE])
      else $error("protect pulse levels wrong");
   a_pvf_levels: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (state_q == EPA_PULSE && cur_q.op == EPA_OP_PROT_VF) |->
      !pins_o.byte_address_lines[EPA_PROT_VFY_BIT] && !pins_o.chip_en_n)
      else $error("protect verify levels wrong");
   a_done_one_cycle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (done_o && clk_en_i) |=> !done_o)
      else $error("done longer than one cycle");
   a_addr_steady: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (state_q == EPA_PULSE && clk_en_i && $past(state_q) == EPA_PULSE) |->
      $stable(pins_o.byte_address_lines))
      else $error("address moved during pulse");
   a_strobe_fall_width: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      ($fell(pins_o.write_strobe_n) && state_q == EPA_PULSE && !clk_en_i) |=>
      !pins_o.write_strobe_n)
      else $error("strobe released while frozen");
endmodule

// File: epa_host_tb.sv
// epa_host_tb: self-checking testbench for the programming-mode controller
`timescale 1ns/1ps
module epa_host_tb;
   import epa_pkg::*;
   // ******************************************************************
   // short counts so the run stays brief
   // ******************************************************************
   localparam int FC = 20;
   localparam int SC = 10;
   localparam int LC = 40;
   localparam int UC = 4;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic clk_en = 1'b1;         // clock enable, dropped in the freeze scenario
   logic [7:0] floating;        // lines that neither end drives
   logic req_valid_i = 1'b0;
   epa_req_t req_i = '0;
   logic req_ready_o;
   logic done_o;
   logic [7:0] rdata_o;
   logic blank_o;
   epa_pins_t pins_o;
   logic [7:0] bus;             // resolved byte lines
   logic [7:0] last_q = 8'h00;  // last bus value, inverted when nobody drives
   logic [7:0] dev_d;
   logic [7:0] dev_oe_n;
   int failures = 0;
   int tests_run = 0;
   int low_cnt;                 // strobe low cycles in one operation
   int ce_bad;                  // strobe low while chip enable is high
   int fight;                   // cycles with both ends driving
   always #2.5 core_clk_i = ~core_clk_i;
   // floating lines must not keep a stale value
   assign floating = pins_o.byte_lines_oe_n & dev_oe_n;
   assign bus = (~pins_o.byte_lines_oe_n & pins_o.byte_lines_o) |
                (pins_o.byte_lines_oe_n & ~dev_oe_n & dev_d) |
                (floating & ~last_q);
   // a released line shows the inverse of its last driven level and stays there
   always @(posedge core_clk_i) begin
      if (!sys_rst_i) last_q <= (bus & ~floating) | (last_q & floating);
   end
   epa_host #(.FAST_CYC(FC), .SHORT_CYC(SC), .FINAL_CYC(LC), .SETUP_CYC(UC)) DUT (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
      .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
      .done_o(done_o), .rdata_o(rdata_o), .blank_o(blank_o),
      .pins_o(pins_o), .byte_lines_i(bus));
   epa_dev_model dev (.pins_i(pins_o), .bus_i(bus), .drv_o(dev_d), .drv_oe_n_o(dev_oe_n));
   // ******************************************************************
   // shared tasks
   // ******************************************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one request, offered for a single cycle, then watched until done
   task automatic do_op(input epa_op_t op, input logic [12:0] a, input logic [7:0] d,
                        input logic fa, input logic fp);
      int n;
      int hv;
      n = 0;
      hv = 0;
      low_cnt = 0;
      ce_bad = 0;
      fight = 0;
      @(posedge core_clk_i);
      req_valid_i <= 1'b1;
      req_i <= '{op, a, d, fa, fp};
      @(posedge core_clk_i);
      req_valid_i <= 1'b0;
      while (n < 3000) begin
         @(posedge core_clk_i);
         #1;
         n++;
         if (done_o === 1'b1) break;
         if (pins_o.write_strobe_n === 1'b0) begin
            low_cnt++;
            if (pins_o.chip_en_n !== 1'b0) ce_bad++;
         end
         if ((~pins_o.byte_lines_oe_n & ~dev_oe_n) !== 8'h00) fight++;
         if (pins_o.test_mode_select !== 1'b0 && op inside {EPA_OP_PROGRAM, EPA_OP_READ}) hv++;
      end
      check(16'(n < 3000), 16'h1);
      check(16'(hv), 16'h0);
      check(16'(fight), 16'h0);
      check(16'(ce_bad), 16'h0);
   endtask
   // ******************************************************************
   // scenarios
   // ******************************************************************
   task automatic t_reset();
      check({pins_o.chip_en_n, pins_o.write_strobe_n, pins_o.out_en_n}, 16'h7);
      check(pins_o.byte_lines_oe_n, 16'hff);
      check(req_ready_o, 16'h1);
   endtask
   task automatic t_erased();
      do_op(EPA_OP_READ, 13'h0000, 8'h00, 1'b0, 1'b0);
      check(rdata_o, 16'hff);
      check(blank_o, 16'h1);
      do_op(EPA_OP_READ, EPA_LAST_ADDR, 8'h00, 1'b0, 1'b0);
      check(rdata_o, 16'hff);
   endtask
   // word 1234 split low byte even, high byte odd, short pulses
   task automatic t_word();
      do_op(EPA_OP_PROGRAM, 13'h0004, 8'h34, 1'b0, 1'b0);
      check(16'(low_cnt), 16'(SC));
      do_op(EPA_OP_PROGRAM, 13'h0005, 8'h12, 1'b0, 1'b0);
      do_op(EPA_OP_READ, 13'h0004, 8'h00, 1'b0, 1'b0);
      check(rdata_o, 16'h34);
      do_op(EPA_OP_READ, 13'h0005, 8'h00, 1'b0, 1'b0);
      check(rdata_o, 16'h12);
   endtask
   // a second program can only clear further bits
   task automatic t_clear();
      do_op(EPA_OP_PROGRAM, 13'h0004, 8'hf0, 1'b1, 1'b0);
      check(16'(low_cnt), 16'(FC));
      do_op(EPA_OP_READ, 13'h0004, 8'h00, 1'b0, 1'b0);
      check(rdata_o, 16'h30);
      check(blank_o, 16'h0);
   endtask
   // unused top byte filled with zeros using a final pulse
   task automatic t_final();
      do_op(EPA_OP_PROGRAM, EPA_LAST_ADDR, EPA_FILL, 1'b1, 1'b1);
      check(16'(low_cnt), 16'(FC + LC));
      do_op(EPA_OP_READ, EPA_LAST_ADDR, 8'h00, 1'b0, 1'b0);
      check(rdata_o, 16'h00);
   endtask
   // enable low at the strobe fall freezes the strobe, stretching it by the frozen cycles
   task automatic t_freeze();
      fork
         do_op(EPA_OP_PROGRAM, 13'h0006, 8'hf0, 1'b0, 1'b0);
         begin
            @(negedge pins_o.write_strobe_n);
            clk_en <= 1'b0;
            repeat (5) @(posedge core_clk_i);
            clk_en <= 1'b1;
         end
      join
      check(16'(low_cnt), 16'(SC + 5));
      do_op(EPA_OP_READ, 13'h0006, 8'h00, 1'b0, 1'b0);
      check(rdata_o, 16'hf0);
   endtask
   // protect only after a passing verify; contents then hidden
   task automatic t_protect();
      do_op(EPA_OP_PROT_VF, 13'h0000, 8'h00, 1'b1, 1'b0);
      check(rdata_o[7], 16'h1);
      do_op(EPA_OP_PROTECT, 13'h0010, 8'h00, 1'b1, 1'b0);
      check(16'(low_cnt), 16'h0);
      do_op(EPA_OP_PROT_VF, 13'h0000, 8'h00, 1'b1, 1'b0);
      check(rdata_o[7], 16'h0);
      do_op(EPA_OP_READ, 13'h0005, 8'h00, 1'b0, 1'b0);
      check(rdata_o, 16'h00);
   endtask
   // ******************************************************************
   // run control
   // ******************************************************************
   task automatic tally_and_finish();
      $display("checks run %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // the whole sequence needs well under a thousand cycles; this limit of 100000 cycles is generous
   initial begin
      #500000;
      failures++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      t_reset();
      t_erased();
      t_word();
      t_clear();
      t_final();
      t_freeze();
      t_protect();
      tally_and_finish();
   end
endmodule

// File: epa_pkg.sv
// epa_pkg: shared types and constants for the eprom programming-mode controller
package epa_pkg;
   // ********************************************************************
   // geometry
   // ********************************************************************
   localparam int EPA_ADDR_W = 13;                 // byte address width, 8k bytes
   localparam int EPA_DATA_W = 8;                  // byte lines width
   localparam logic [12:0] EPA_LAST_ADDR = 13'h1fff; // top byte address
   localparam logic [7:0] EPA_ERASED = 8'hff;      // erased byte value
   localparam logic [7:0] EPA_FILL = 8'h00;        // fill for unused bytes
   localparam int EPA_PROT_SET_BIT = 4;            // address bit high in protect
   localparam int EPA_PROT_VFY_BIT = 6;            // address bit low in protect verify
   localparam int EPA_TOP_LINE = 7;                // byte line that carries protect bit
   // ********************************************************************
   // timing, clock period 5 ns
   // ********************************************************************
   localparam int EPA_CLK_PS = 5000;               // clock period in ps
   localparam int EPA_FAST_MIN_NS = 950000;        // fast initial pulse least 0.95 ms
   localparam int EPA_FAST_NOM_NS = 1000000;       // fast initial pulse nominal 1 ms
   localparam int EPA_FAST_MAX_NS = 1050000;       // fast initial pulse most 1.05 ms
   localparam int EPA_FINAL_MIN_NS = 2850000;      // final pulse least 2.85 ms
   localparam int EPA_FINAL_MAX_NS = 78750000;     // final pulse most 78.75 ms
   localparam int EPA_SHORT_MIN_NS = 95000;        // short initial pulse least 95 us
   localparam int EPA_SHORT_NOM_NS = 100000;       // short initial pulse nominal 100 us
   localparam int EPA_SHORT_MAX_NS = 105000;       // short initial pulse most 105 us
   localparam int EPA_SETUP_NS = 2000;             // pin setup and data hold 2 us
   // nominal figures sit within both bounds, so they are used as counts
   localparam int EPA_FAST_CYC = (EPA_FAST_NOM_NS * 1000) / EPA_CLK_PS;
   localparam int EPA_SHORT_CYC = (EPA_SHORT_NOM_NS * 1000) / EPA_CLK_PS;
   // the product passes the range of int, so it is formed in 64 bits
   localparam int EPA_FINAL_CYC =
      int'((longint'(EPA_FINAL_MIN_NS) * 1000 + EPA_CLK_PS - 1) / EPA_CLK_PS);
   localparam int EPA_SETUP_CYC = (EPA_SETUP_NS * 1000 + EPA_CLK_PS - 1) / EPA_CLK_PS;
   localparam int EPA_CNT_W = 24;                  // width of the timing counter
   // ********************************************************************
   // types
   // ********************************************************************
   typedef enum logic [2:0] {
      EPA_OP_PROGRAM = 3'h0,   // program one byte
      EPA_OP_READ    = 3'h1,   // read or verify one byte
      EPA_OP_PROTECT = 3'h2,   // program the protect bit
      EPA_OP_PROT_VF = 3'h3    // read the protect bit
   } epa_op_t;
   // request from the user side
   typedef struct packed {
      epa_op_t op;                   // operation
      logic [12:0] addr;             // byte address
      logic [7:0] data;              // byte to program
      logic fast_alg;                // 1 fast 1 ms pulses, 0 short 100 us pulses
      logic final_pulse;             // add a final pulse (fast only)
   } epa_req_t;
   // pins driven toward the device
   typedef struct packed {
      logic chip_en_n;               // chip enable, low active
      logic out_en_n;                // output enable, low active
      logic write_strobe_n;          // program strobe, low active
      logic test_mode_select;        // high selects protect modes
      logic [12:0] byte_address_lines; // byte address
      logic [7:0] byte_lines_o;      // byte out value
      logic [7:0] byte_lines_oe_n;   // low while this end drives
   } epa_pins_t;
endpackage

// File: epa_sync.sv
// epa_sync: three-stage synchroniser for the byte lines read back from the device
`timescale 1ns/1ps
module epa_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   // data
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o,
   output logic stable_o
);
   logic [W-1:0] s1_q, s2_q, s3_q;   // stages; s1 is seen only by s2
   logic [W-1:0] s1_d, s2_d, s3_d;
   // next values
   always_comb begin
      s1_d = async_i;
      s2_d = s1_q;
      s3_d = s2_q;
   end
   // register stages
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else if (clk_en_i) begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
      end
   end
   // a value counts once stage two and three agree
   assign sync_o = s3_q;
   assign stable_o = (s2_q == s3_q);
endmodule
